// ==== core/osd_display_ram_write_port.sv ====
// Purpose: Processor port to the display RAM plus control-code handling
// Assumes: Fetch, scan and character timing come from logic on mclk_i
// Notes:   Display word is {select, colour[2:0], code[5:0]}
`timescale 1ns/1ps
module osd_display_ram_write_port #(
	parameter int ADDR_W = 7
) (
	input  wire logic                          mclk_i,
	input  wire logic                          rstn_i,
	input  wire logic [7:0]                    sfr_addr_i,
	input  wire logic [7:0]                    sfr_wdata_i,
	input  wire logic                          sfr_wr_i,
	input  wire logic                          sfr_rd_i,
	output logic      [7:0]                    sfr_rdata_o,
	input  wire logic                          fetch_en_i,
	input  wire logic [osd_pkg::PTR_W-1:0]     fetch_addr_i,
	output logic      [osd_pkg::WORD_W-1:0]    fetch_word_o,
	output logic                               fetch_valid_o,
	input  wire logic                          vscan_start_i,
	input  wire logic                          char_left_i,
	input  wire logic                          char_half_i,
	input  wire logic                          osd_enable_i,
	output logic      [osd_pkg::COL_W-1:0]     fg_colour_o,
	output logic                               bg_select_o,
	output logic      [osd_pkg::COL_W-1:0]     bg_colour_o,
	output logic                               row_end_o,
	output logic                               blank_o,
	output logic                               end_flag_o,
	output logic                               short_row_o,
	output logic                               double_o,
	output logic                               shadow_o
);
	import osd_pkg::*;

	// Only the documented depth of 128 words is served
	if (ADDR_W != PTR_W) begin : g_bad_width
		$error("ADDR_W must equal the pointer width");
	end

	// Classify a six-bit code; used on fetch and in checks
	function automatic code_class_t classify(input logic [CODE_W-1:0] c);
		unique case (c)
			CODE_ROWEND: classify = CLS_ROW_END;
			CODE_BLANK:  classify = CLS_BLANK;
			CODE_BGBLNK: classify = CLS_BG_BLANK;
			CODE_SPLIT:  classify = CLS_SPLIT;
			default:     classify = CLS_CHAR;
		endcase
	endfunction

	// ----------------------------------------
	// Display RAM and its two ports
	// ----------------------------------------
	dram_if #(.ADDR_W(ADDR_W), .DATA_W(WORD_W)) bus ();

	display_ram #(.ADDR_W(ADDR_W), .DATA_W(WORD_W)) u_ram (
		.mclk_i (mclk_i),
		.rstn_i (rstn_i),
		.port   (bus.ram)
	);

	// ----------------------------------------
	// Register bus decode
	// ----------------------------------------
	logic wr_attr;
	logic wr_code;
	logic wr_ptr;

	assign wr_attr = sfr_wr_i && (sfr_addr_i == ATTR_ADDR);
	assign wr_code = sfr_wr_i && (sfr_addr_i == CODE_ADDR);
	assign wr_ptr  = sfr_wr_i && (sfr_addr_i == PTR_ADDR);

	// ----------------------------------------
	// Attribute latch, pointer, read data
	// ----------------------------------------
	logic [7:0]        attr_r, attr_nxt;
	logic [PTR_W-1:0]  ptr_r, ptr_nxt;
	logic [7:0]        rdata_r, rdata_nxt;

	// Reserved attribute bits are not kept so they read as zero
	always_comb begin
		attr_nxt  = attr_r;
		ptr_nxt   = ptr_r;
		rdata_nxt = rdata_r;
		if (wr_attr) begin
			attr_nxt = sfr_wdata_i & ATTR_MASK;
		end
		if (wr_ptr) begin
			ptr_nxt = sfr_wdata_i[PTR_W-1:0];
		end else if (wr_code) begin
			ptr_nxt = ptr_r + 7'h01;
		end
		if (sfr_rd_i) begin
			unique case (sfr_addr_i)
				ATTR_ADDR: rdata_nxt = attr_r;
				PTR_ADDR:  rdata_nxt = {1'b0, ptr_r};
				default:   rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			attr_r  <= ATTR_RST;
			ptr_r   <= PTR_RST;
			rdata_r <= 8'h00;
		end else begin
			attr_r  <= attr_nxt;
			ptr_r   <= ptr_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// RAM write joins the latch with the low code bits only
	assign bus.wr_en   = wr_code;
	assign bus.wr_addr = ptr_r;
	assign bus.wr_data = {attr_r[SEL_BIT], attr_r[COL_W-1:0], sfr_wdata_i[CODE_W-1:0]};

	// Fetch side never waits on the processor
	assign bus.rd_en   = fetch_en_i;
	assign bus.rd_addr = fetch_addr_i;

	// ----------------------------------------
	// Fetched word interpretation
	// ----------------------------------------
	logic [WORD_W-1:0] cur_r, cur_nxt;
	logic              valid_r, valid_nxt;
	logic              split_r, split_nxt;
	logic [COL_W-1:0]  fg_r, fg_nxt;
	logic              sel_r, sel_nxt;
	logic [COL_W-1:0]  bg_r, bg_nxt;
	logic              rowend_r, rowend_nxt;
	logic              blank_r, blank_nxt;
	logic              end_r, end_nxt;
	logic              short_r, short_nxt;
	logic              dbl_r, dbl_nxt;
	logic              shad_r, shad_nxt;
	code_class_t       fcls;
	code_class_t       ccls;
	logic [COL_W-1:0]  fcol;
	logic              fsel;

	assign fcls = classify(bus.rd_data[CODE_W-1:0]);
	assign ccls = classify(cur_r[CODE_W-1:0]);
	assign fcol = cur_r[CODE_W+COL_W-1:CODE_W];
	assign fsel = cur_r[WORD_W-1];

	// Row flags: a row end fetched in the scan-start cycle still counts
	always_comb begin
		cur_nxt    = cur_r;
		valid_nxt  = fetch_en_i;
		split_nxt  = split_r;
		fg_nxt     = fg_r;
		sel_nxt    = sel_r;
		bg_nxt     = bg_r;
		rowend_nxt = rowend_r;
		blank_nxt  = blank_r;
		end_nxt    = end_r;
		short_nxt  = short_r;
		dbl_nxt    = dbl_r;
		shad_nxt   = shad_r;
		if (vscan_start_i) begin
			end_nxt   = 1'b0;
			short_nxt = 1'b0;
			dbl_nxt   = 1'b0;
			shad_nxt  = 1'b0;
		end
		if (valid_r) begin
			cur_nxt = bus.rd_data;
			if (fcls == CLS_ROW_END) begin
				if (bus.rd_data[CODE_W+END_BIT-1]) begin
					end_nxt = 1'b1;
				end else begin
					short_nxt = bus.rd_data[CODE_W+SHORT_BIT];
					dbl_nxt   = bus.rd_data[CODE_W+DBL_BIT];
					shad_nxt  = bus.rd_data[CODE_W+SHAD_BIT];
				end
			end
		end
		// Character shown from its left edge onward
		if (char_left_i) begin
			rowend_nxt = (ccls == CLS_ROW_END);
			blank_nxt  = (ccls != CLS_CHAR) && (ccls != CLS_ROW_END);
			split_nxt  = 1'b0;
			unique case (ccls)
				CLS_CHAR: begin
					fg_nxt  = fcol;
					sel_nxt = fsel;
				end
				CLS_BG_BLANK: begin
					if (osd_enable_i) begin
						sel_nxt = fsel;
						bg_nxt  = fcol;
					end
				end
				CLS_SPLIT: begin
					split_nxt = osd_enable_i;
				end
				CLS_BLANK: begin
					bg_nxt = bg_r;
				end
				CLS_ROW_END: begin
					blank_nxt = 1'b0;
				end
			endcase
		end else if (char_half_i && split_r) begin
			sel_nxt   = fsel;
			bg_nxt    = fcol;
			split_nxt = 1'b0;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			cur_r    <= '0;
			valid_r  <= 1'b0;
			split_r  <= 1'b0;
			fg_r     <= BG_RST;
			sel_r    <= 1'b0;
			bg_r     <= BG_RST;
			rowend_r <= 1'b0;
			blank_r  <= 1'b0;
			end_r    <= 1'b0;
			short_r  <= 1'b0;
			dbl_r    <= 1'b0;
			shad_r   <= 1'b0;
		end else begin
			cur_r    <= cur_nxt;
			valid_r  <= valid_nxt;
			split_r  <= split_nxt;
			fg_r     <= fg_nxt;
			sel_r    <= sel_nxt;
			bg_r     <= bg_nxt;
			rowend_r <= rowend_nxt;
			blank_r  <= blank_nxt;
			end_r    <= end_nxt;
			short_r  <= short_nxt;
			dbl_r    <= dbl_nxt;
			shad_r   <= shad_nxt;
		end
	end

	// ----------------------------------------
	// Outputs, all from flip-flops
	// ----------------------------------------
	assign sfr_rdata_o   = rdata_r;
	assign fetch_word_o  = bus.rd_data;
	assign fetch_valid_o = valid_r;
	assign fg_colour_o   = fg_r;
	assign bg_select_o   = sel_r;
	assign bg_colour_o   = bg_r;
	assign row_end_o     = rowend_r;
	assign blank_o       = blank_r;
	assign end_flag_o    = end_r;
	assign short_row_o   = short_r;
	assign double_o      = dbl_r;
	assign shadow_o      = shad_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);

	logic fetch_rowend;
	assign fetch_rowend = valid_r && (fcls == CLS_ROW_END);

	a_attr_no_write: assert property (wr_attr |-> !bus.wr_en)
		else $error("attribute write reached the RAM");
	a_attr_capture: assert property (wr_attr |=> attr_r == ($past(sfr_wdata_i) & ATTR_MASK))
		else $error("attribute latch missed a write");
	a_code_store: assert property (wr_code |-> bus.wr_en && bus.wr_addr == ptr_r
		&& bus.wr_data == {attr_r[SEL_BIT], attr_r[2:0], sfr_wdata_i[5:0]})
		else $error("code write stored wrong word");
	a_ptr_step_wrap: assert property (wr_code |=> ptr_r == 7'($past(ptr_r) + 7'h01))
		else $error("pointer did not advance by one");
	a_ptr_read_back: assert property (sfr_rd_i && sfr_addr_i == PTR_ADDR |=> sfr_rdata_o == {1'b0, $past(ptr_r)})
		else $error("pointer read wrong");
	a_fetch_indep: assert property (fetch_en_i && wr_code |=> fetch_valid_o)
		else $error("fetch lost during a write");
	a_fg_on_char: assert property (char_left_i && ccls == CLS_CHAR |=> fg_colour_o == $past(fcol))
		else $error("foreground colour not taken");
	a_bg_blank_left: assert property (char_left_i && ccls == CLS_BG_BLANK && osd_enable_i
		|=> bg_colour_o == $past(fcol) && bg_select_o == $past(fsel))
		else $error("background blank not applied at left edge");
	a_split_half: assert property (char_left_i && ccls == CLS_SPLIT && osd_enable_i ##1
		(!char_left_i && char_half_i) |=> bg_colour_o == $past(fcol))
		else $error("split blank not applied at half");
	a_blank_keeps: assert property (char_left_i && ccls == CLS_BLANK |=> $stable(bg_colour_o))
		else $error("plain blank changed background");
	a_end_stops: assert property (fetch_rowend && bus.rd_data[CODE_W+END_BIT-1] |=> end_flag_o)
		else $error("end flag not set");
	a_row_mode: assert property (fetch_rowend && !bus.rd_data[CODE_W+END_BIT-1]
		|=> {short_row_o, double_o, shadow_o} == $past(bus.rd_data[CODE_W+2:CODE_W]))
		else $error("row mode flags wrong");
	a_vscan_clear: assert property (vscan_start_i && !fetch_rowend
		|=> !end_flag_o && !short_row_o && !double_o && !shadow_o)
		else $error("row flags survived scan start");

	// Pointer moves only on its own write or a code write
	a_ptr_load: assert property (wr_ptr |=> ptr_r == $past(sfr_wdata_i[PTR_W-1:0]))
		else $error("pointer load lost");
	a_ptr_hold: assert property (!wr_ptr && !wr_code |=> $stable(ptr_r))
		else $error("pointer moved without a write");
	a_no_stray_write: assert property (!wr_code |-> !bus.wr_en)
		else $error("RAM written without a code write");
	a_attr_reserved: assert property (sfr_rd_i && sfr_addr_i == ATTR_ADDR
		|=> sfr_rdata_o[7:5] == 3'h0 && !sfr_rdata_o[3])
		else $error("reserved attribute bits read back");
	// Blanks flag themselves; split at the left edge and disabled loads leave colours alone
	a_blank_flag: assert property (char_left_i && (ccls == CLS_BLANK || ccls == CLS_BG_BLANK
		|| ccls == CLS_SPLIT) |=> blank_o && !row_end_o)
		else $error("blank not flagged");
	a_split_left_hold: assert property (char_left_i && ccls == CLS_SPLIT |=> $stable(bg_colour_o))
		else $error("split blank changed colour at left edge");
	a_bg_off_hold: assert property (char_left_i && ccls == CLS_BG_BLANK && !osd_enable_i
		|=> $stable(bg_colour_o) && $stable(bg_select_o))
		else $error("background loaded while display off");
	a_row_end_flag: assert property (char_left_i && ccls == CLS_ROW_END |=> row_end_o && !blank_o)
		else $error("row end not flagged");

	c_code_write: cover property (wr_attr ##1 wr_code ##1 wr_code);
	c_ptr_wrap: cover property (wr_code && ptr_r == 7'h7F);
	c_split_seen: cover property (split_r && char_half_i);
	c_end_row: cover property (fetch_rowend ##[1:20] vscan_start_i);
	c_fetch_on_write: cover property (fetch_en_i && wr_code);
endmodule // osd_display_ram_write_port

// ==== core/osd_pkg.sv ====
// Purpose: Shared constants and types for the display RAM write port
// Assumes: Eight-bit processor register bus, one clock
// Notes:   Display word is {select, colour[2:0], code[5:0]}
package osd_pkg;
	// ----------------------------------------
	// Register addresses
	// ----------------------------------------
	localparam logic [7:0] ATTR_ADDR = 8'h98;
	localparam logic [7:0] CODE_ADDR = 8'h99;
	localparam logic [7:0] PTR_ADDR  = 8'h9A;

	// ----------------------------------------
	// Field layout and reset values
	// ----------------------------------------
	localparam int         PTR_W     = 7;
	localparam int         CODE_W    = 6;
	localparam int         COL_W     = 3;
	localparam int         WORD_W    = 10;
	localparam int         SEL_BIT   = 4;
	localparam int         END_BIT   = 4;
	localparam int         SHORT_BIT = 2;
	localparam int         DBL_BIT   = 1;
	localparam int         SHAD_BIT  = 0;
	localparam logic [7:0] ATTR_MASK = 8'h17;
	localparam logic [7:0] ATTR_RST  = 8'h00;
	localparam logic [6:0] PTR_RST   = 7'h00;
	localparam logic [2:0] BG_RST    = 3'h0;

	// ----------------------------------------
	// Control character codes
	// ----------------------------------------
	localparam logic [5:0] CODE_BLANK  = 6'h3C;
	localparam logic [5:0] CODE_ROWEND = 6'h3D;
	localparam logic [5:0] CODE_BGBLNK = 6'h3E;
	localparam logic [5:0] CODE_SPLIT  = 6'h3F;

	typedef enum logic [2:0] {
		CLS_CHAR,
		CLS_ROW_END,
		CLS_BLANK,
		CLS_BG_BLANK,
		CLS_SPLIT
	} code_class_t;
endpackage

// ==== core/dram_if.sv ====
// Purpose: Write and read ports of the display RAM
// Assumes: Both ports on the processor clock
// Notes:   Separate ports so writes never block fetches
`timescale 1ns/1ps
interface dram_if #(
	parameter int ADDR_W = 7,
	parameter int DATA_W = 10
) ();
	logic              wr_en;
	logic [ADDR_W-1:0] wr_addr;
	logic [DATA_W-1:0] wr_data;
	logic              rd_en;
	logic [ADDR_W-1:0] rd_addr;
	logic [DATA_W-1:0] rd_data;

	modport ram  (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
	modport user (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
endinterface

// ==== core/display_ram.sv ====
// Purpose: Simple dual-port display memory, one write port and one read port
// Assumes: One clock; read data registered
// Notes:   Reading an address in the cycle it is written returns old data
`timescale 1ns/1ps
module display_ram #(
	parameter int ADDR_W = 7,
	parameter int DATA_W = 10
) (
	input  wire logic mclk_i,
	input  wire logic rstn_i,
	dram_if.ram       port
);
	localparam int DEPTH = 1 << ADDR_W;

	logic [DATA_W-1:0] mem [DEPTH];
	logic [DATA_W-1:0] rd_r;

	// ----------------------------------------
	// Storage and registered read
	// ----------------------------------------
	// Memory array carries no reset; contents are software's job
	always_ff @(posedge mclk_i) begin
		if (port.wr_en) begin
			mem[port.wr_addr] <= port.wr_data;
		end
	end

	// Read port is independent of the write port
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			rd_r <= '0;
		end else if (port.rd_en) begin
			rd_r <= mem[port.rd_addr];
		end
	end

	assign port.rd_data = rd_r;
endmodule // display_ram

// ==== dv/mcu_core_model.sv ====
// Purpose: Processor core model issuing register bus cycles
// Assumes: Strobes are one-cycle pulses launched at the falling edge
// Notes:   Released address and data show the inverse of the last value
`timescale 1ns/1ps
module mcu_core_model (
	input  wire logic       mclk_i,
	input  wire logic [7:0] sfr_rdata_i,
	output logic      [7:0] sfr_addr_o,
	output logic      [7:0] sfr_wdata_o,
	output logic            sfr_wr_o,
	output logic            sfr_rd_o
);
	// ----------------------------------------
	// Bus cycles
	// ----------------------------------------
	initial begin
		sfr_addr_o  = 8'h00;
		sfr_wdata_o = 8'h00;
		sfr_wr_o    = 1'b0;
		sfr_rd_o    = 1'b0;
	end

	// Release inverts so a stale value never passes for a live one
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk_i);
		sfr_addr_o  = a;
		sfr_wdata_o = d;
		sfr_wr_o    = 1'b1;
		@(negedge mclk_i);
		sfr_wr_o    = 1'b0;
		sfr_addr_o  = ~a;
		sfr_wdata_o = ~d;
	endtask

	// Read data stands from the read edge on, taken at the next low phase
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge mclk_i);
		sfr_addr_o = a;
		sfr_rd_o   = 1'b1;
		@(negedge mclk_i);
		sfr_rd_o   = 1'b0;
		sfr_addr_o = ~a;
		d          = sfr_rdata_i;
	endtask
endmodule // mcu_core_model

// ==== dv/osd_display_ram_write_port_tb.sv ====
// Purpose: Self-checking bench for the display RAM write port
// Assumes: Video-side strobes driven here, register bus by the core model
// Notes:   Fetched words are checked from a queue by a monitor process
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin failures++; \
	$display("[ERR] %s exp %h got %h", nm, ex, got); end end
module osd_display_ram_write_port_tb;
	import osd_pkg::*;
	logic        mclk_i = 1'b0;
	logic        rstn_i, sfr_wr_i, sfr_rd_i, fetch_en_i, fetch_valid_o;
	logic        vscan_start_i, char_left_i, char_half_i, osd_enable_i;
	logic [7:0]  sfr_addr_i, sfr_wdata_i, sfr_rdata_o, rv, r;
	logic [6:0]  fetch_addr_i, ptr_m;
	logic [9:0]  fetch_word_o, hd;
	logic [2:0]  fg_colour_o, bg_colour_o;
	logic        bg_select_o, row_end_o, blank_o, end_flag_o, short_row_o, double_o, shadow_o;
	logic [9:0]  mem [128];
	logic [9:0]  exp_q [$];
	logic [7:0]  attr_m;
	logic [7:0]  rt [4] = '{8'h04, 8'h02, 8'h01, 8'h10};
	logic [3:0]  rf [4] = '{4'h4, 4'h2, 4'h1, 4'h9};
	int          failures = 0;
	int          cmp_count = 0;
	int          cycles = 0;

	always #2.5 mclk_i = ~mclk_i;

	// ----------------------------------------
	// Design and core model
	// ----------------------------------------
	osd_display_ram_write_port osd_display_ram_write_port_i (.mclk_i(mclk_i), .rstn_i(rstn_i),
		.sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
		.sfr_rdata_o(sfr_rdata_o), .fetch_en_i(fetch_en_i), .fetch_addr_i(fetch_addr_i),
		.fetch_word_o(fetch_word_o), .fetch_valid_o(fetch_valid_o), .vscan_start_i(vscan_start_i),
		.char_left_i(char_left_i), .char_half_i(char_half_i), .osd_enable_i(osd_enable_i),
		.fg_colour_o(fg_colour_o), .bg_select_o(bg_select_o), .bg_colour_o(bg_colour_o),
		.row_end_o(row_end_o), .blank_o(blank_o), .end_flag_o(end_flag_o), .short_row_o(short_row_o),
		.double_o(double_o), .shadow_o(shadow_o));
	mcu_core_model mcu_core_model_i (.mclk_i(mclk_i), .sfr_rdata_i(sfr_rdata_o), .sfr_addr_o(sfr_addr_i),
		.sfr_wdata_o(sfr_wdata_i), .sfr_wr_o(sfr_wr_i), .sfr_rd_o(sfr_rd_i));

	// ----------------------------------------
	// Stimulus tasks
	// ----------------------------------------
	task automatic set_attr(input logic [7:0] a);
		mcu_core_model_i.wr(ATTR_ADDR, a);
		attr_m = a;
	endtask

	// Expected word keeps only bits 4, 2..0 of the latch and 5..0 of the code
	task automatic put_code(input logic [7:0] d);
		mcu_core_model_i.wr(CODE_ADDR, d);
		mem[ptr_m] = {attr_m[4], attr_m[2:0], d[5:0]};
		ptr_m = ptr_m + 7'h01;
	endtask

	task automatic fetch(input logic [6:0] a);
		@(negedge mclk_i);
		fetch_en_i   = 1'b1;
		fetch_addr_i = a;
		exp_q.push_back(mem[a]);
		@(negedge mclk_i);
		fetch_en_i   = 1'b0;
		fetch_addr_i = ~a;
	endtask

	// One spare cycle first, so the fetched word is current before the strobe
	task automatic pulse(input int k);
		@(negedge mclk_i);
		@(negedge mclk_i);
		if (k == 0) char_left_i = 1'b1; else if (k == 1) char_half_i = 1'b1; else vscan_start_i = 1'b1;
		@(negedge mclk_i);
		char_left_i   = 1'b0;
		char_half_i   = 1'b0;
		vscan_start_i = 1'b0;
	endtask

	// Bits 7..6 of the code are set on purpose, they must be dropped
	task automatic show(input logic [7:0] a, input logic [5:0] c);
		set_attr(a);
		put_code({2'b11, c});
		fetch(ptr_m - 7'h01);
		pulse(0);
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Monitor and timeout
	// ----------------------------------------
	always @(negedge mclk_i) begin
		if (fetch_valid_o === 1'b1) begin
			hd = (exp_q.size() > 0) ? exp_q.pop_front() : 10'h3FF;
			`CHK("fetch_word", hd, fetch_word_o)
		end
	end

	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			report_and_stop();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rstn_i = 1'b0;
		fetch_en_i = 1'b0;
		fetch_addr_i = 7'h00;
		vscan_start_i = 1'b0;
		char_left_i = 1'b0;
		char_half_i = 1'b0;
		osd_enable_i = 1'b1;
		attr_m = 8'h00;
		ptr_m = 7'h00;
		void'($urandom(35));
		repeat (20) @(negedge mclk_i);
		rstn_i = 1'b1;
		`CHK("outputs", 13'h0000, {fg_colour_o, bg_select_o, bg_colour_o, row_end_o, blank_o, end_flag_o,
			short_row_o, double_o, shadow_o})
		mcu_core_model_i.rd(PTR_ADDR, rv);
		`CHK("ptr_reset", 8'h00, rv)
		// Attribute read-back keeps only the defined bits
		repeat (4) begin
			r = 8'($urandom);
			set_attr(r);
			mcu_core_model_i.rd(ATTR_ADDR, rv);
			`CHK("attr_read", r & 8'h17, rv)
		end
		mcu_core_model_i.wr(PTR_ADDR, 8'hFE);
		ptr_m = 7'h7E;
		mcu_core_model_i.rd(PTR_ADDR, rv);
		`CHK("ptr_read", 8'h7E, rv)
		// Four random writes across the top of the RAM
		for (int i = 0; i < 4; i++) begin
			set_attr(8'($urandom));
			put_code(8'($urandom));
		end
		mcu_core_model_i.rd(PTR_ADDR, rv);
		`CHK("ptr_wrap", 8'h02, rv)
		for (int i = 0; i < 4; i++) fetch(7'h7E + 7'(i));
		// One attribute load serves a run; latch writes touch neither RAM nor pointer
		set_attr(8'h15);
		fetch(7'h01);
		put_code(8'h41);
		put_code(8'h02);
		fetch(7'h02);
		fetch(7'h03);
		mcu_core_model_i.rd(PTR_ADDR, rv);
		`CHK("ptr_attr", 8'h04, rv)
		// A code write and a display fetch in the same cycle
		fork
			put_code(8'h05);
			fetch(7'h02);
		join
		fetch(7'h04);
		mcu_core_model_i.rd(CODE_ADDR, rv);
		`CHK("code_read", 8'h00, rv)
		mcu_core_model_i.rd(8'h55, rv);
		`CHK("unmapped", 8'h00, rv)
		// Character interpretation at the left edge
		show(8'h15, 6'h21);
		`CHK("fg", 3'h5, fg_colour_o)
		`CHK("sel_char", 3'h4, {bg_select_o, row_end_o, blank_o})
		show(8'h13, CODE_BGBLNK);
		`CHK("bg_blank", 5'h17, {bg_select_o, bg_colour_o, blank_o})
		show(8'h06, CODE_BLANK);
		`CHK("plain", 4'h7, {bg_colour_o, blank_o})
		osd_enable_i = 1'b0;
		show(8'h16, CODE_BGBLNK);
		`CHK("bg_off", 3'h3, bg_colour_o)
		osd_enable_i = 1'b1;
		show(8'h02, CODE_SPLIT);
		`CHK("split_left", 3'h3, bg_colour_o)
		pulse(1);
		`CHK("split_half", 4'h2, {bg_select_o, bg_colour_o})
		// Random words fetched earlier may have left row flags set
		pulse(2);
		// Row-end flags {end, short, double, shadow}
		for (int i = 0; i < 4; i++) begin
			show(rt[i], CODE_ROWEND);
			`CHK("row_flags", {1'b1, rf[i]}, {row_end_o, end_flag_o, short_row_o, double_o, shadow_o})
		end
		pulse(2);
		`CHK("scan_clear", 4'h0, {end_flag_o, short_row_o, double_o, shadow_o})
		repeat (4) @(negedge mclk_i);
		report_and_stop();
	end
endmodule // osd_display_ram_write_port_tb
